// File: hdl/ldtp_cfg.svh
// Constants of the display timing and power control block
`ifndef LDTP_CFG_SVH
`define LDTP_CFG_SVH

`define LDTP_ROW_BITS      132
`define LDTP_SEG_COUNT     133
`define LDTP_LINE_BITS     6
`define LDTP_PWR_BITS      3
`define LDTP_DIV_BITS      8
`define LDTP_LINE_DIV      8'h40
`define LDTP_DUTY_LINES    6'h21
`define LDTP_PWR_RST       3'h0
`define LDTP_START_RST     6'h00
`define LDTP_PWR_BOOST_BIT 2
`define LDTP_PWR_REG_BIT   1
`define LDTP_PWR_FOL_BIT   0
`define LDTP_FIFO_DEPTH    16

`endif

// File: hdl/ldtp_pkg.sv
// Types of the display timing and power control block
package ldtp_pkg;

  typedef enum logic [2:0] {
    LDTP_CMD_POWER,
    LDTP_CMD_DISP_ON,
    LDTP_CMD_REVERSE,
    LDTP_CMD_ALL_ON,
    LDTP_CMD_START_LINE
  } ldtp_cmd_e;

  typedef enum logic [1:0] {
    LDTP_LVL_V0,
    LDTP_LVL_V2,
    LDTP_LVL_V3,
    LDTP_LVL_V5
  } ldtp_level_e;

endpackage : ldtp_pkg

// File: hdl/ldtp_fifo.sv
// Row buffer between display RAM read port and the row latch
`timescale 1ns/1ns
`default_nettype none

module ldtp_fifo #(
  parameter int WIDTH = 133,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      wr_ptr_nxt;
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      rd_ptr_nxt;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                       (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (push)
    begin
      wr_ptr_nxt = wr_ptr_r + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_nxt = rd_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Storage carries no reset; only pointers define validity
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

endmodule : ldtp_fifo

`default_nettype wire

// File: hdl/ldtp_seg_mux.sv
// Segment drive level multiplexer fed by the row latch
`timescale 1ns/1ns
`default_nettype none

`include "ldtp_cfg.svh"

module ldtp_seg_mux (
  input  wire logic                          ref_clk,
  input  wire logic                          arst_n,
  input  wire logic [`LDTP_SEG_COUNT-1:0]    row,
  input  wire logic                          ac_phase,
  input  wire logic                          com_active,
  input  wire logic                          reverse,
  input  wire logic                          all_on,
  output logic      [2*`LDTP_SEG_COUNT-1:0]  segment_output
);

  logic [2*`LDTP_SEG_COUNT-1:0] seg_r;
  logic [2*`LDTP_SEG_COUNT-1:0] seg_nxt;

  function automatic ldtp_pkg::ldtp_level_e level_of(
    input logic lit,
    input logic phase
  );
    if (phase)
    begin
      level_of = lit ? ldtp_pkg::LDTP_LVL_V0 : ldtp_pkg::LDTP_LVL_V2;
    end
    else
    begin
      level_of = lit ? ldtp_pkg::LDTP_LVL_V5 : ldtp_pkg::LDTP_LVL_V3;
    end
  endfunction : level_of

  always_comb
  begin
    logic lit;
    lit     = 1'b0;
    seg_nxt = '0;
    for (int i = 0; i < `LDTP_SEG_COUNT; i++)
    begin
      lit = com_active && (all_on || (row[i] ^ reverse));
      seg_nxt[2*i +: 2] = level_of(lit, ac_phase);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seg_r <= '0;
    end
    else
    begin
      seg_r <= seg_nxt;
    end
  end

  assign segment_output = seg_r;

endmodule : ldtp_seg_mux

`default_nettype wire

// File: hdl/ldtp_timing.sv
// Display timing, row latch and power enable control
//
// Behaviour
// - Line clock advances line counter and strobes the row latch.
// - Each line clock latches one 133-bit row (132 RAM bits plus icon) and drives segments; a tick with an empty buffer latches nothing.
// - Row fetch uses its own RAM read port, independent of host.
// - AC toggle derived from line clock, period of two frames.
// - Slave mode takes AC toggle and line clock as inputs.
// - AC toggle change gives high scan start pulse at line clock fall.
// - Scan start driven only in master, released in slave.
// - Master divides oscillator to line clock and drives it out.
// - Latch holds one row for exactly one common scan period; an empty buffer at a tick keeps the old row another line.
// - Reverse, on/off, all-on affect output path only, not RAM.
// - Each of 133 segments picks one of four levels.
// - Oscillator runs only in master mode.
// - Power command loads three-bit enable field.
// - Bit 2 booster, bit 1 regulator, bit 0 follower, high on.
// - Booster runs only while oscillator runs.
// - Built-in supply usable only in master mode.
// - AC toggle change presets line counter from start line.
// - Line counter increments once per line clock, gives row address.
`timescale 1ns/1ns
`default_nettype none

`include "ldtp_cfg.svh"

module ldtp_timing (
  input  wire logic                           ref_clk,
  input  wire logic                           arst_n,
  input  wire logic                           master_mode,
  input  wire logic                           cmd_valid,
  input  wire logic [2:0]                     cmd_op,
  input  wire logic [5:0]                     cmd_arg,
  output logic                                ram_row_req,
  output logic      [`LDTP_LINE_BITS-1:0]     ram_row_addr,
  input  wire logic                           ram_row_valid,
  output logic                                ram_row_ready,
  input  wire logic [`LDTP_ROW_BITS-1:0]      ram_row_data,
  input  wire logic                           ram_icon_bit,
  input  wire logic                           display_line_clock_i,
  output logic                                display_line_clock_o,
  output logic                                display_line_clock_oe,
  input  wire logic                           lcd_ac_toggle_i,
  output logic                                lcd_ac_toggle_o,
  output logic                                lcd_ac_toggle_oe,
  input  wire logic                           display_off_sync_i,
  output logic                                display_off_sync_o,
  output logic                                display_off_sync_oe,
  output logic                                common_scan_start_o,
  output logic                                common_scan_start_oe,
  output logic                                osc_running,
  output logic                                booster_en,
  output logic                                regulator_en,
  output logic                                follower_en,
  output logic      [`LDTP_PWR_BITS-1:0]      power_circuit_enables,
  output logic      [2*`LDTP_SEG_COUNT-1:0]   segment_output
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic ms_s1_r;
  logic ms_s2_r;
  logic cl_s1_r;
  logic cl_s2_r;
  logic cl_s3_r;
  logic fr_s1_r;
  logic fr_s2_r;
  logic dof_s1_r;
  logic dof_s2_r;
  logic master;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ms_s1_r  <= 1'b0;
      ms_s2_r  <= 1'b0;
      cl_s1_r  <= 1'b0;
      cl_s2_r  <= 1'b0;
      cl_s3_r  <= 1'b0;
      fr_s1_r  <= 1'b0;
      fr_s2_r  <= 1'b0;
      dof_s1_r <= 1'b0;
      dof_s2_r <= 1'b0;
    end
    else
    begin
      ms_s1_r  <= master_mode;
      ms_s2_r  <= ms_s1_r;
      cl_s1_r  <= display_line_clock_i;
      cl_s2_r  <= cl_s1_r;
      cl_s3_r  <= cl_s2_r;
      fr_s1_r  <= lcd_ac_toggle_i;
      fr_s2_r  <= fr_s1_r;
      dof_s1_r <= display_off_sync_i;
      dof_s2_r <= dof_s1_r;
    end
  end

  assign master = ms_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // Command registers

  logic [`LDTP_PWR_BITS-1:0]  pwr_r;
  logic [`LDTP_PWR_BITS-1:0]  pwr_nxt;
  logic                       disp_on_r;
  logic                       disp_on_nxt;
  logic                       reverse_r;
  logic                       reverse_nxt;
  logic                       all_on_r;
  logic                       all_on_nxt;
  logic [`LDTP_LINE_BITS-1:0] start_r;
  logic [`LDTP_LINE_BITS-1:0] start_nxt;

  always_comb
  begin
    pwr_nxt     = pwr_r;
    disp_on_nxt = disp_on_r;
    reverse_nxt = reverse_r;
    all_on_nxt  = all_on_r;
    start_nxt   = start_r;
    if (cmd_valid)
    begin
      unique case (cmd_op)
        ldtp_pkg::LDTP_CMD_POWER:      pwr_nxt = cmd_arg[`LDTP_PWR_BITS-1:0];
        ldtp_pkg::LDTP_CMD_DISP_ON:    disp_on_nxt = cmd_arg[0];
        ldtp_pkg::LDTP_CMD_REVERSE:    reverse_nxt = cmd_arg[0];
        ldtp_pkg::LDTP_CMD_ALL_ON:     all_on_nxt = cmd_arg[0];
        ldtp_pkg::LDTP_CMD_START_LINE: start_nxt = cmd_arg;
        default:                       pwr_nxt = pwr_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_r     <= `LDTP_PWR_RST;
      disp_on_r <= 1'b0;
      reverse_r <= 1'b0;
      all_on_r  <= 1'b0;
      start_r   <= `LDTP_START_RST;
    end
    else
    begin
      pwr_r     <= pwr_nxt;
      disp_on_r <= disp_on_nxt;
      reverse_r <= reverse_nxt;
      all_on_r  <= all_on_nxt;
      start_r   <= start_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line clock, AC toggle and scan start

  logic [`LDTP_DIV_BITS-1:0]  div_r;
  logic [`LDTP_DIV_BITS-1:0]  div_nxt;
  logic                       cl_r;
  logic                       cl_nxt;
  logic [`LDTP_LINE_BITS-1:0] frame_line_r;
  logic [`LDTP_LINE_BITS-1:0] frame_line_nxt;
  logic                       fr_r;
  logic                       fr_nxt;
  logic                       fr_seen_r;
  logic                       dyo_r;
  logic                       dyo_nxt;
  logic                       div_wrap;
  logic                       line_tick;
  logic                       fr_now;
  logic                       fr_chg;

  assign div_wrap = (div_r == `LDTP_LINE_DIV - 8'h01);
  // line clock falling edge is the line event
  assign line_tick = master ? (div_wrap && cl_r) : (cl_s3_r && !cl_s2_r);
  assign fr_now = master ? fr_r : fr_s2_r;
  assign fr_chg = (fr_now != fr_seen_r);

  always_comb
  begin
    div_nxt        = div_r;
    cl_nxt         = cl_r;
    frame_line_nxt = frame_line_r;
    fr_nxt         = fr_r;
    dyo_nxt        = dyo_r;
    if (!master)
    begin
      div_nxt        = '0;
      cl_nxt         = 1'b0;
      frame_line_nxt = '0;
      dyo_nxt        = 1'b0;
    end
    else
    begin
      div_nxt = div_wrap ? '0 : div_r + 8'h01;
      if (div_wrap)
      begin
        cl_nxt = !cl_r;
      end
      if (line_tick)
      begin
        dyo_nxt = 1'b0;
        if (frame_line_r == `LDTP_DUTY_LINES - 6'h01)
        begin
          frame_line_nxt = '0;
          fr_nxt         = !fr_r;
          // pulse at trailing edge, same cycle as toggle
          dyo_nxt        = 1'b1;
        end
        else
        begin
          frame_line_nxt = frame_line_r + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_r        <= '0;
      cl_r         <= 1'b0;
      frame_line_r <= '0;
      fr_r         <= 1'b0;
      fr_seen_r    <= 1'b0;
      dyo_r        <= 1'b0;
    end
    else
    begin
      div_r        <= div_nxt;
      cl_r         <= cl_nxt;
      frame_line_r <= frame_line_nxt;
      fr_r         <= fr_nxt;
      fr_seen_r    <= fr_now;
      dyo_r        <= dyo_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line counter and row fetch

  logic [`LDTP_LINE_BITS-1:0] lc_r;
  logic [`LDTP_LINE_BITS-1:0] lc_nxt;
  logic                       req_r;
  logic                       req_nxt;

  always_comb
  begin
    lc_nxt = lc_r;
    if (fr_chg)
    begin
      lc_nxt = start_r;
    end
    else if (line_tick)
    begin
      lc_nxt = lc_r + 6'h01;
    end
    // private read port, one request per line tick and one on AC change
    req_nxt = line_tick || fr_chg;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lc_r  <= '0;
      req_r <= 1'b0;
    end
    else
    begin
      lc_r  <= lc_nxt;
      req_r <= req_nxt;
    end
  end

  assign ram_row_req  = req_r;
  assign ram_row_addr = lc_r;

  ////////////////////////////////////////////////////////////////////////
  // Row buffer and latch

  logic [`LDTP_SEG_COUNT-1:0] buf_out;
  logic                       buf_valid;
  logic                       buf_pop;
  logic [`LDTP_SEG_COUNT-1:0] latch_r;
  logic [`LDTP_SEG_COUNT-1:0] latch_nxt;

  // Rows wait in the buffer so a slow RAM port never stalls timing
  ldtp_fifo #(
    .WIDTH (`LDTP_SEG_COUNT),
    .DEPTH (`LDTP_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_valid  (ram_row_valid),
    .in_ready  (ram_row_ready),
    .in_data   ({ram_icon_bit, ram_row_data}),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out)
  );

  assign buf_pop = line_tick && buf_valid;

  always_comb
  begin
    latch_nxt = latch_r;
    // latch once per line, hold until next
    if (buf_pop)
    begin
      latch_nxt = buf_out;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latch_r <= '0;
    end
    else
    begin
      latch_r <= latch_nxt;
    end
  end

  ldtp_seg_mux u_seg (
    .ref_clk        (ref_clk),
    .arst_n         (arst_n),
    .row            (latch_r),
    .ac_phase       (fr_now),
    .com_active     (master ? disp_on_r : !dof_s2_r),
    .reverse        (reverse_r),
    .all_on         (all_on_r),
    .segment_output (segment_output)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pins and power enables

  // drive link pins only as master
  assign display_line_clock_o  = cl_r;
  assign display_line_clock_oe = master;
  assign lcd_ac_toggle_o       = fr_r;
  assign lcd_ac_toggle_oe      = master;
  assign display_off_sync_o    = !disp_on_r;
  assign display_off_sync_oe   = master;
  assign common_scan_start_o   = dyo_r;
  assign common_scan_start_oe  = master;

  assign osc_running           = master;
  assign power_circuit_enables = pwr_r;
  assign booster_en   = master && osc_running && pwr_r[`LDTP_PWR_BOOST_BIT];
  assign regulator_en = master && pwr_r[`LDTP_PWR_REG_BIT];
  assign follower_en  = master && pwr_r[`LDTP_PWR_FOL_BIT];

endmodule : ldtp_timing

`default_nettype wire

// File: verif/ldtp_properties.sv
// Port checks for the display timing block
`timescale 1ns/1ns
`default_nettype none

module ldtp_properties (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [5:0] cmd_arg,
  input wire logic       ram_row_req,
  input wire logic       display_line_clock_o,
  input wire logic       display_line_clock_oe,
  input wire logic       lcd_ac_toggle_o,
  input wire logic       lcd_ac_toggle_oe,
  input wire logic       display_off_sync_o,
  input wire logic       display_off_sync_oe,
  input wire logic       common_scan_start_o,
  input wire logic       common_scan_start_oe,
  input wire logic       osc_running,
  input wire logic       booster_en,
  input wire logic       regulator_en,
  input wire logic       follower_en,
  input wire logic [2:0] power_circuit_enables
);
  wire logic       cl   = display_line_clock_o;
  wire logic       css  = common_scan_start_o;
  wire logic [2:0] pw   = power_circuit_enables;
  wire logic       pcmd = cmd_valid && cmd_op == 3'h0;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  a_scan_oe_mode:
    assert property (common_scan_start_oe == lcd_ac_toggle_oe)
    else $error("scan start enable differs from mode");
  a_osc_master:
    assert property (osc_running == display_line_clock_oe)
    else $error("oscillator state differs from mode");
  a_power_gate:
    assert property ({booster_en, regulator_en, follower_en}
                     == (pw & {3{osc_running}}))
    else $error("power enables differ from field");
  a_power_load:
    assert property (pcmd |=> {3'h0, pw} == ($past(cmd_arg) & 6'h07))
    else $error("power field not loaded");
  a_power_hold:
    assert property (!pcmd |=> $stable(pw))
    else $error("power field changed without command");
  a_scan_on_ac:
    assert property ($changed(lcd_ac_toggle_o) && lcd_ac_toggle_oe
                     |-> $rose(css))
    else $error("no scan start pulse at ac change");
  a_scan_one_line:
    assert property ($rose(css) && common_scan_start_oe
                     |-> ##127 css ##1 !css)
    else $error("scan start pulse not one line wide");
  a_half_period:
    assert property ($changed(cl) && display_line_clock_oe
                     |=> $stable(cl)[*8] ##56 $changed(cl))
    else $error("line clock half period wrong");
  a_req_on_tick:
    assert property ($fell(cl) && display_line_clock_oe
                     |-> ram_row_req)
    else $error("no row request after line tick");
  a_off_follows:
    assert property (cmd_valid && cmd_op == 3'h1 && display_off_sync_oe
                     |-> ##[1:2] display_off_sync_o
                         == ~|($past(cmd_arg) & 6'h01))
    else $error("display off output wrong");
endmodule : ldtp_properties

bind ldtp_timing ldtp_properties u_props (
  .ref_clk, .arst_n, .cmd_valid, .cmd_op, .cmd_arg, .ram_row_req,
  .display_line_clock_o, .display_line_clock_oe, .lcd_ac_toggle_o,
  .lcd_ac_toggle_oe, .display_off_sync_o, .display_off_sync_oe,
  .common_scan_start_o, .common_scan_start_oe, .osc_running,
  .booster_en, .regulator_en, .follower_en, .power_circuit_enables
);

`default_nettype wire

// File: verif/ldtp_ram_model.sv
// Display RAM row source answering row requests
`timescale 1ns/1ns
`default_nettype none

module ldtp_ram_model (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         req,
  input  wire logic         ready,
  input  wire logic         fill,
  input  wire logic         flood,
  input  wire logic [3:0]   lag,
  output logic              valid,
  output logic      [131:0] data,
  output logic              icon
);
  logic [3:0] cnt;
  logic       pend;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {valid, pend, cnt} <= '0;
      data <= '1;
      icon <= 1'b1;
    end
    else
    begin
      if (req)
      begin
        pend <= 1'b1;
        cnt  <= lag;
      end
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      if (valid && ready && !flood)
      begin
        // Released lines show the inverse, not the old row
        valid <= 1'b0;
        data  <= ~data;
        icon  <= ~icon;
      end
      else if (!valid && (flood || (pend && cnt == 4'h0 && !req)))
      begin
        valid <= 1'b1;
        pend  <= 1'b0;
        data  <= {132{fill}};
        icon  <= fill;
      end
    end
  end
endmodule : ldtp_ram_model

`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the display timing block
`timescale 1ns/1ns
`default_nettype none

`include "ldtp_cfg.svh"

`define CHK(nm, ex, got) \
  begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  logic         ref_clk = 0, arst_n = 0, master_mode = 1, cmd_valid = 0;
  logic [2:0]   cmd_op = 0;
  logic [5:0]   cmd_arg = 0;
  logic         fill = 1, flood = 0, link_cl = 0, link_run = 0;
  logic         tb_ac = 0, tb_off = 0;
  logic [3:0]   lag = 4'h3;
  logic         ram_row_req, ram_row_valid, ram_row_ready, ram_icon_bit;
  logic [5:0]   ram_row_addr;
  logic [131:0] ram_row_data;
  logic         display_line_clock_o, display_line_clock_oe;
  logic         lcd_ac_toggle_o, lcd_ac_toggle_oe;
  logic         display_off_sync_o, display_off_sync_oe;
  logic         common_scan_start_o, common_scan_start_oe, osc_running;
  logic         booster_en, regulator_en, follower_en;
  logic [2:0]   power_circuit_enables;
  logic [265:0] segment_output;
  int           n_fail = 0, comparisons = 0, cycles = 0, t0;
  // Shared pins: whoever has the enable drives the wire
  wire logic    display_line_clock_i =
    display_line_clock_oe ? display_line_clock_o : link_cl;
  wire logic    lcd_ac_toggle_i = lcd_ac_toggle_oe ? lcd_ac_toggle_o : tb_ac;
  wire logic    display_off_sync_i =
    display_off_sync_oe ? display_off_sync_o : tb_off;

  always #5 ref_clk = ~ref_clk;
  always #40 if (link_run) link_cl = ~link_cl;

  ldtp_timing uut (
    .ref_clk, .arst_n, .master_mode, .cmd_valid, .cmd_op, .cmd_arg,
    .ram_row_req, .ram_row_addr, .ram_row_valid, .ram_row_ready,
    .ram_row_data, .ram_icon_bit, .display_line_clock_i,
    .display_line_clock_o, .display_line_clock_oe, .lcd_ac_toggle_i,
    .lcd_ac_toggle_o, .lcd_ac_toggle_oe, .display_off_sync_i,
    .display_off_sync_o, .display_off_sync_oe, .common_scan_start_o,
    .common_scan_start_oe, .osc_running, .booster_en, .regulator_en,
    .follower_en, .power_circuit_enables, .segment_output
  );

  ldtp_ram_model ram (
    .ref_clk, .arst_n, .req(ram_row_req), .ready(ram_row_ready), .fill,
    .flood, .lag, .valid(ram_row_valid), .data(ram_row_data),
    .icon(ram_icon_bit)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Hang guard well above the planned run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic send(input logic [2:0] op, input logic [5:0] arg);
    @(negedge ref_clk);
    {cmd_valid, cmd_op, cmd_arg} = {1'b1, op, arg};
    @(negedge ref_clk);
    cmd_valid = 0;
    @(negedge ref_clk);
  endtask : send

  // Samples segment 0 and the icon segment six cycles after the line clock falls
  task automatic seg_check(input logic lit);
    logic [1:0] ex;
    @(negedge display_line_clock_i);
    repeat (6) @(negedge ref_clk);
    ex = lcd_ac_toggle_i ? (lit ? ldtp_pkg::LDTP_LVL_V0 : ldtp_pkg::LDTP_LVL_V2)
                         : (lit ? ldtp_pkg::LDTP_LVL_V5 : ldtp_pkg::LDTP_LVL_V3);
    `CHK("segment 0", ex, segment_output[1:0])
    `CHK("icon segment", ex, segment_output[265:264])
  endtask : seg_check

  task automatic lines(input int n);
    repeat (n) @(negedge display_line_clock_i);
  endtask : lines

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge ref_clk);
    arst_n = 1;
    repeat (3) @(negedge ref_clk);
    `CHK("power reset", 3'h0, power_circuit_enables)
    for (int p = 0; p < 8; p++)
    begin
      send(3'h0, 6'(p));
      `CHK("power field", 3'(p), power_circuit_enables)
      `CHK("enables", 3'(p), {booster_en, regulator_en, follower_en})
    end
    send(3'h1, 6'h01);
    lines(3);
    seg_check(1);
    send(3'h2, 6'h01);
    seg_check(0);
    send(3'h3, 6'h01);
    seg_check(1);
    send(3'h3, 6'h00);
    send(3'h2, 6'h00);
    fill = 0;
    lag = 4'h9;
    lines(4);
    seg_check(0);
    send(3'h1, 6'h00);
    fill = 1;
    lines(4);
    seg_check(0);
    send(3'h4, 6'h05);
    // Frame length between two scan start pulses
    @(posedge common_scan_start_o);
    t0 = cycles;
    @(posedge common_scan_start_o);
    `CHK("frame cycles", 2 * `LDTP_LINE_DIV * `LDTP_DUTY_LINES, cycles - t0)
    // Preset lands one cycle after the toggle
    repeat (2) @(negedge ref_clk);
    `CHK("line preset", 6'h05, ram_row_addr)
    lines(1);
    @(negedge ref_clk);
    `CHK("line step", 6'h06, ram_row_addr)
    flood = 1;
    repeat (300) @(negedge ref_clk);
    `CHK("fifo full", 1'b0, ram_row_ready)
    flood = 0;
    // Prefetch keeps the buffer full; each tick frees one slot
    lines(20);
    @(negedge ref_clk);
    `CHK("fifo frees at tick", 1'b1, ram_row_ready)
    // Second reset into slave mode
    arst_n = 0;
    master_mode = 0;
    // Rows must return within one 8-cycle slave line
    lag = 4'h3;
    repeat (3) @(negedge ref_clk);
    {arst_n, link_run, tb_ac, tb_off} = 4'b1111;
    repeat (4) @(negedge ref_clk);
    `CHK("scan start oe", 1'b0, common_scan_start_oe)
    `CHK("line clock oe", 1'b0, display_line_clock_oe)
    `CHK("oscillator", 1'b0, osc_running)
    send(3'h0, 6'h07);
    `CHK("slave enables", 3'h0, {booster_en, regulator_en, follower_en})
    seg_check(0);
    {tb_ac, tb_off} = 2'b00;
    repeat (40) @(negedge ref_clk);
    seg_check(1);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
